// ---- svt_map.svh ----
// Address map, passwords, field positions, reset values and counts
// Assumes inclusion by the supervision timer files only
`ifndef SVT_MAP_SVH
`define SVT_MAP_SVH
// ****************************************
// Read addresses
// ****************************************
`define SVT_ADDR_CS 16'hFF10
`define SVT_ADDR_CNT 16'hFF11
`define SVT_ADDR_RST 16'hFF1F
// Word write addresses (address bits 15 to 1)
`define SVT_WADDR_CS 15'h7F88
`define SVT_WADDR_RST 15'h7F8F
// ****************************************
// Passwords in the upper byte of a write
// ****************************************
`define SVT_PW_CNT 8'h5A
`define SVT_PW_CS 8'hA5
`define SVT_PW_RESET_OUTPUT_ENABLE 8'h5A
`define SVT_PW_WATCHDOG_RESET_FLAG 8'hA5
`define SVT_WATCHDOG_RESET_FLAG_CLR_DATA 8'h00
// ****************************************
// Field positions and reset values
// ****************************************
`define SVT_CS_OVF 7
`define SVT_CS_MODE 6
`define SVT_CS_RUN 5
`define SVT_RST_OE 6
`define SVT_CS_RSVD 2'h3
`define SVT_RST_RSVD 6'h3F
`define SVT_CS_RESET 8'h18
`define SVT_CNT_RESET 8'h00
`define SVT_CNT_MAX 8'hFF
`define SVT_RST_RESET 8'h3F
// ****************************************
// Reset pulse lengths in system clock cycles
// ****************************************
`define SVT_IRST_CYC 10'd518
`define SVT_RESET_OUT_PIN_CYC 10'd132
// Divider shifts for select codes 000 to 111
`define SVT_DIV0 4'd1
`define SVT_DIV1 4'd5
`define SVT_DIV2 4'd6
`define SVT_DIV3 4'd7
`define SVT_DIV4 4'd8
`define SVT_DIV5 4'd9
`define SVT_DIV6 4'd11
`define SVT_DIV7 4'd12
`endif

// ---- svt_pkg.sv ----
// Types shared by the supervision timer and its prescaler
// Assumes the map header holds all numbers
package svt_pkg;
    // CPU bus request, one cycle strobes
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic word;
        logic rd;
    } svt_bus_req_t;

    // Control/status fields
    typedef struct packed {
        logic ovf;
        logic mode;
        logic run;
        logic [2:0] cks;
    } svt_ctrl_t;
endpackage

// ---- svt_prescaler.sv ----
// Free-running system clock divider giving one-cycle count enables
// Assumes the same clock and reset as the timer
`timescale 1ns/1ps
`include "svt_map.svh"
module svt_prescaler #(
    parameter int WIDTH = 12
) (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic [2:0] SEL_I,
    output logic TICK_O
);
    import svt_pkg::*;

    logic [WIDTH-1:0] div_r;
    logic [WIDTH-1:0] div_nxt;

    // ****************************************
    // Select code to divider shift
    // ****************************************
    function automatic logic [3:0] shift_of(input logic [2:0] sel);
        case (sel)
            3'h0: shift_of = `SVT_DIV0;
            3'h1: shift_of = `SVT_DIV1;
            3'h2: shift_of = `SVT_DIV2;
            3'h3: shift_of = `SVT_DIV3;
            3'h4: shift_of = `SVT_DIV4;
            3'h5: shift_of = `SVT_DIV5;
            3'h6: shift_of = `SVT_DIV6;
            default: shift_of = `SVT_DIV7;
        endcase
    endfunction

    // Divider next value
    always_comb begin
        div_nxt = div_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    // Divider register
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            div_r <= '0;
        end else begin
            div_nxt_hold: div_r <= div_nxt;
        end
    end

    // One tick when the low bits wrap
    always_comb begin
        logic [WIDTH-1:0] mask;
        mask = '0;
        mask = ~({WIDTH{1'b1}} << shift_of(SEL_I));
        TICK_O = ((div_r & mask) == mask);
    end
endmodule

// ---- svt_rst_mon.sv ----
// Model of the chip reset logic and interrupt side of the timer
// Assumes the timer's clock and the pulled-up reset-out pin level
`timescale 1ns/1ps
module svt_rst_mon (
    input wire logic CLOCK_I,
    input wire logic CHIP_RST_I,
    input wire logic RESET_OUT_PIN_PIN_I,
    input wire logic IRQ_I,
    output int CHIP_LEN_O,
    output int RESET_OUT_PIN_LEN_O,
    output logic IRQ_IN_RST_O
);
    int chip_cnt = 0;
    int reset_out_pin_cnt = 0;
    int chip_len = 0;
    int reset_out_pin_len = 0;
    logic irq_seen = 1'b0;
    // ********
    // Pulse length capture
    // ********
    always @(posedge CLOCK_I) begin
        if (CHIP_RST_I === 1'b1) begin
            chip_cnt <= chip_cnt + 1;
            if (IRQ_I === 1'b1) irq_seen <= 1'b1;
        end else if (chip_cnt != 0) begin
            chip_len <= chip_cnt;
            chip_cnt <= 0;
        end
        // Pin is low while the reset is driven out
        if (RESET_OUT_PIN_PIN_I === 1'b0) begin
            reset_out_pin_cnt <= reset_out_pin_cnt + 1;
        end else if (reset_out_pin_cnt != 0) begin
            reset_out_pin_len <= reset_out_pin_cnt;
            reset_out_pin_cnt <= 0;
        end
    end
    assign CHIP_LEN_O = chip_len;
    assign RESET_OUT_PIN_LEN_O = reset_out_pin_len;
    assign IRQ_IN_RST_O = irq_seen;
endmodule

// ---- svt_timer.sv ----
// Supervision timer: counter, mode, overflow flag and watchdog reset
// Assumes a byte/word CPU bus with one-cycle strobes on CLOCK_I
//
// What this block does
// - Counter counts selected prescaled ticks while running
// - Interval-mode wrap from maximum to zero sets overflow flag
// - Counter held zero when stopped or reset
// - Interval mode overflow requests an interrupt
// - Watchdog mode overflow requests reset instead
// - Interrupt request follows the overflow flag
// - Flag cleared by software only by read-one then write-zero
// - Flag, mode, run clear in any standby
// - Clock select survives software standby only
// - Control bits 4 and 3 read one
// - Select codes pick eight system clock divisions
// - Interrupts recur at the full overflow interval
// - Watchdog overflow resets the whole chip
// - Reset also driven out when enabled
// - Password-protected word writes; byte writes ignored
// - Internal reset 518 cycles, output 132
// - Watchdog flag set by overflow, cleared externally
`timescale 1ns/1ps
`include "svt_map.svh"
module svt_timer #(
    parameter int DIV_WIDTH = 12
) (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire svt_pkg::svt_bus_req_t BUS_I,
    input wire logic HW_STANDBY_I,
    input wire logic SW_STANDBY_I,
    output logic [7:0] RD_DATA_O,
    output logic INTERVAL_IRQ_O,
    output logic CHIP_RST_O,
    output logic RESET_OUT_PIN_OUT_O,
    output logic RESET_OUT_PIN_OE_O
);
    import svt_pkg::*;

    svt_ctrl_t ctrl_r, ctrl_nxt;
    logic [7:0] count_r, count_nxt;
    logic ovf_armed_r, ovf_armed_nxt;
    logic watchdog_reset_flag_r, watchdog_reset_flag_nxt;
    logic watchdog_reset_flag_armed_r, watchdog_reset_flag_armed_nxt;
    logic reset_output_enable_r, reset_output_enable_nxt;
    logic [9:0] irst_r, irst_nxt;
    logic [9:0] reset_out_pin_r, reset_out_pin_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic tick;
    logic wrap;
    logic wd_ovf;
    logic wr_cs_word, wr_rst_word;
    logic [7:0] pw, wd;
    logic [7:0] cs_view, rst_view;

    // ****************************************
    // Prescaler
    // ****************************************
    svt_prescaler #(.WIDTH(DIV_WIDTH)) u_presc (
        .CLOCK_I(CLOCK_I),
        .NRST_I(NRST_I),
        .SEL_I(ctrl_r.cks),
        .TICK_O(tick)
    );

    // ****************************************
    // Decode and events
    // ****************************************
    assign pw = BUS_I.wdata[15:8];
    assign wd = BUS_I.wdata[7:0];
    assign wr_cs_word = BUS_I.wr & BUS_I.word & (BUS_I.addr[15:1] == `SVT_WADDR_CS);
    assign wr_rst_word = BUS_I.wr & BUS_I.word & (BUS_I.addr[15:1] == `SVT_WADDR_RST);
    assign wrap = ctrl_r.run & tick & (count_r == `SVT_CNT_MAX);
    assign wd_ovf = wrap & ctrl_r.mode;
    assign cs_view = {ctrl_r.ovf, ctrl_r.mode, ctrl_r.run, `SVT_CS_RSVD, ctrl_r.cks};
    assign rst_view = {watchdog_reset_flag_r, reset_output_enable_r, `SVT_RST_RSVD};

    // Timer registers next values
    always_comb begin
        ctrl_nxt = ctrl_r;
        count_nxt = count_r;
        ovf_armed_nxt = ovf_armed_r;
        watchdog_reset_flag_nxt = watchdog_reset_flag_r;
        watchdog_reset_flag_armed_nxt = watchdog_reset_flag_armed_r;
        reset_output_enable_nxt = reset_output_enable_r;
        rdata_nxt = rdata_r;
        // Reads: data only, plus clear arming
        if (BUS_I.rd) begin
            unique case (BUS_I.addr)
                `SVT_ADDR_CS: rdata_nxt = cs_view;
                `SVT_ADDR_CNT: rdata_nxt = count_r;
                `SVT_ADDR_RST: rdata_nxt = rst_view;
                default: rdata_nxt = 8'h00;
            endcase
            if (BUS_I.addr == `SVT_ADDR_CS && ctrl_r.ovf) begin
                ovf_armed_nxt = 1'b1;
            end
            if (BUS_I.addr == `SVT_ADDR_RST && watchdog_reset_flag_r) begin
                watchdog_reset_flag_armed_nxt = 1'b1;
            end
        end
        // Counting
        if (ctrl_r.run && tick) begin
            count_nxt = count_r + 8'h01;
        end
        // Password writes
        if (wr_cs_word && pw == `SVT_PW_CNT) begin
            count_nxt = wd;
        end
        if (wr_cs_word && pw == `SVT_PW_CS) begin
            ctrl_nxt.mode = wd[`SVT_CS_MODE];
            ctrl_nxt.run = wd[`SVT_CS_RUN];
            ctrl_nxt.cks = wd[2:0];
            if (!wd[`SVT_CS_OVF] && ovf_armed_r) begin
                ctrl_nxt.ovf = 1'b0;
                ovf_armed_nxt = 1'b0;
            end
        end
        if (wr_rst_word && pw == `SVT_PW_RESET_OUTPUT_ENABLE) begin
            reset_output_enable_nxt = wd[`SVT_RST_OE];
        end
        if (wr_rst_word && pw == `SVT_PW_WATCHDOG_RESET_FLAG && wd == `SVT_WATCHDOG_RESET_FLAG_CLR_DATA && watchdog_reset_flag_armed_r) begin
            watchdog_reset_flag_nxt = 1'b0;
            watchdog_reset_flag_armed_nxt = 1'b0;
        end
        // Overflow sets win over software clears
        if (wrap && !ctrl_r.mode) begin
            ctrl_nxt.ovf = 1'b1;
        end
        if (wd_ovf) begin
            watchdog_reset_flag_nxt = 1'b1;
        end
        // Stopped counter sits at zero
        if (!ctrl_nxt.run) begin
            count_nxt = `SVT_CNT_RESET;
        end
        // Standby and internal chip reset
        if (SW_STANDBY_I) begin
            ctrl_nxt.ovf = 1'b0;
            ctrl_nxt.mode = 1'b0;
            ctrl_nxt.run = 1'b0;
            count_nxt = `SVT_CNT_RESET;
            ovf_armed_nxt = 1'b0;
        end
        if (HW_STANDBY_I || irst_r != 10'd0) begin
            ctrl_nxt = '0;
            count_nxt = `SVT_CNT_RESET;
            ovf_armed_nxt = 1'b0;
        end
    end

    // Timer registers
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_r <= '0;
            count_r <= `SVT_CNT_RESET;
            ovf_armed_r <= 1'b0;
            watchdog_reset_flag_r <= 1'b0;
            watchdog_reset_flag_armed_r <= 1'b0;
            reset_output_enable_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            count_r <= count_nxt;
            ovf_armed_r <= ovf_armed_nxt;
            watchdog_reset_flag_r <= watchdog_reset_flag_nxt;
            watchdog_reset_flag_armed_r <= watchdog_reset_flag_armed_nxt;
            reset_output_enable_r <= reset_output_enable_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // Reset pulse counters
    // ****************************************
    always_comb begin
        irst_nxt = (irst_r != 10'd0) ? irst_r - 10'd1 : 10'd0;
        reset_out_pin_nxt = (reset_out_pin_r != 10'd0) ? reset_out_pin_r - 10'd1 : 10'd0;
        if (wd_ovf) begin
            irst_nxt = `SVT_IRST_CYC;
            reset_out_pin_nxt = reset_output_enable_r ? `SVT_RESET_OUT_PIN_CYC : 10'd0;
        end
    end

    // Pulse counter registers
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irst_r <= 10'd0;
            reset_out_pin_r <= 10'd0;
        end else begin
            irst_r <= irst_nxt;
            reset_out_pin_r <= reset_out_pin_nxt;
        end
    end

    // Outputs
    assign RD_DATA_O = rdata_r;
    assign INTERVAL_IRQ_O = ctrl_r.ovf;
    assign CHIP_RST_O = (irst_r != 10'd0);
    assign RESET_OUT_PIN_OUT_O = 1'b0;
    assign RESET_OUT_PIN_OE_O = (reset_out_pin_r != 10'd0);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);

    logic [9:0] hi_irst_r, hi_reset_out_pin_r;
    // Length of each reset pulse so far, for the checks
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            hi_irst_r <= 10'd0;
            hi_reset_out_pin_r <= 10'd0;
        end else begin
            hi_irst_r <= CHIP_RST_O ? hi_irst_r + 10'd1 : 10'd0;
            hi_reset_out_pin_r <= RESET_OUT_PIN_OE_O ? hi_reset_out_pin_r + 10'd1 : 10'd0;
        end
    end

    sequence s_int_wrap;
        wrap && !ctrl_r.mode && !HW_STANDBY_I && !SW_STANDBY_I && irst_r == 10'd0;
    endsequence

    a_count_stop: assert property (!ctrl_r.run |-> count_r == 8'h00)
        else $error("counter not zero while stopped");
    a_count_step: assert property (ctrl_r.run && tick && !BUS_I.wr && !SW_STANDBY_I
        && !HW_STANDBY_I && irst_r == 10'd0 |=> count_r == $past(count_r) + 8'h01)
        else $error("counter missed a tick");
    a_ovf_set: assert property (s_int_wrap |=> ctrl_r.ovf && count_r == 8'h00)
        else $error("overflow flag not set on wrap");
    a_irq_flag: assert property ($rose(INTERVAL_IRQ_O)
        |-> $past(wrap) && !$past(ctrl_r.mode) && ctrl_r.ovf)
        else $error("interrupt request not tied to flag");
    a_wd_reset: assert property (wd_ovf |=> CHIP_RST_O && watchdog_reset_flag_r && !$rose(ctrl_r.ovf))
        else $error("watchdog overflow gave no reset");
    a_irst_len: assert property ($fell(CHIP_RST_O) |-> hi_irst_r == `SVT_IRST_CYC)
        else $error("internal reset length wrong");
    a_reset_out_pin_len: assert property ($fell(RESET_OUT_PIN_OE_O) |-> hi_reset_out_pin_r == `SVT_RESET_OUT_PIN_CYC)
        else $error("reset-out length wrong");
    a_ovf_noset: assert property (!ctrl_r.ovf && !wrap |=> !ctrl_r.ovf)
        else $error("overflow flag set without overflow");
    a_cks_keep: assert property (SW_STANDBY_I && !HW_STANDBY_I && irst_r == 10'd0
        && !wr_cs_word |=> ctrl_r.cks == $past(ctrl_r.cks) && !ctrl_r.run)
        else $error("select lost in software standby");
    a_rsvd_read: assert property (BUS_I.rd && BUS_I.addr == `SVT_ADDR_CS
        |=> RD_DATA_O[4:3] == 2'h3)
        else $error("reserved bits not read as one");
endmodule

// ---- testbench.sv ----
// Self-checking bench for the supervision timer
// Assumes the timer, prescaler and reset model are compiled first
`timescale 1ns/1ps
module testbench;
    import svt_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    svt_bus_req_t bus = '0;
    logic hw_sb = 1'b0;
    logic sw_sb = 1'b0;
    logic [7:0] rdata;
    logic irq, chip_rst, reset_out_pin_out, reset_out_pin_oe, reset_out_pin_pin, irq_in_rst;
    int chip_len, reset_out_pin_len;
    int cyc = 0;
    int fails = 0;
    int cmp_count = 0;
    // ********
    // Clock, pin and instances
    // ********
    always #4 clk = ~clk;
    assign reset_out_pin_pin = reset_out_pin_oe ? reset_out_pin_out : 1'b1; // Pull-up when released
    svt_timer i_dut (.CLOCK_I(clk), .NRST_I(nrst), .BUS_I(bus),
        .HW_STANDBY_I(hw_sb), .SW_STANDBY_I(sw_sb), .RD_DATA_O(rdata),
        .INTERVAL_IRQ_O(irq), .CHIP_RST_O(chip_rst), .RESET_OUT_PIN_OUT_O(reset_out_pin_out),
        .RESET_OUT_PIN_OE_O(reset_out_pin_oe));
    svt_rst_mon i_mon (.CLOCK_I(clk), .CHIP_RST_I(chip_rst), .RESET_OUT_PIN_PIN_I(reset_out_pin_pin),
        .IRQ_I(irq), .CHIP_LEN_O(chip_len), .RESET_OUT_PIN_LEN_O(reset_out_pin_len),
        .IRQ_IN_RST_O(irq_in_rst));
    // ********
    // Bus tasks and checks
    // ********
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge clk);
        bus <= {a, d, 1'b1, w, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= {a, 16'h0000, 1'b0, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        chk($sformatf("read %h", a), {24'h0, e}, {24'h0, rdata});
    endtask
    // Bounded wait on irq (0) or chip reset (1); checks whether it ran out
    task automatic wait_sig(input int s, input logic v, input int lim, input logic to);
        int i;
        i = 0;
        #1;
        while (((s == 0) ? irq : chip_rst) !== v && i < lim) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk("wait limit", {31'h0, to}, {31'h0, i >= lim});
    endtask
    task automatic standby(input logic hw);
        @(posedge clk);
        if (hw) hw_sb <= 1'b1;
        else sw_sb <= 1'b1;
        @(posedge clk);
        hw_sb <= 1'b0;
        sw_sb <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // ********
    // Test sequence
    // ********
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(16'hFF10, 8'h18);
        rd(16'hFF11, 8'h00);
        rd(16'hFF1F, 8'h3F);
        rd(16'hFF12, 8'h00);
        wr(16'hFF10, 16'hA520, 1'b0);
        wr(16'hFF10, 16'hC320, 1'b1);
        rd(16'hFF10, 8'h18);
        $display("Test reset and protection done");
        wr(16'hFF10, 16'hA520, 1'b1);
        wr(16'hFF10, 16'h5AFE, 1'b1);
        wait_sig(0, 1'b1, 100, 1'b0);
        wr(16'hFF10, 16'hA520, 1'b1);
        @(posedge clk);
        #1;
        chk("irq after unarmed clear", 32'h1, {31'h0, irq});
        rd(16'hFF10, 8'hB8);
        wr(16'hFF10, 16'hA520, 1'b1);
        wr(16'hFF10, 16'h5A00, 1'b1);
        #1;
        chk("irq after clear", 32'h0, {31'h0, irq});
        wait_sig(0, 1'b1, 500, 1'b1);
        wait_sig(0, 1'b1, 20, 1'b0);
        rd(16'hFF10, 8'hB8);
        wr(16'hFF10, 16'hA507, 1'b1);
        wr(16'hFF10, 16'hA587, 1'b1);
        rd(16'hFF10, 8'h1F);
        rd(16'hFF11, 8'h00);
        $display("Test interval done");
        wr(16'hFF10, 16'hA567, 1'b1);
        wr(16'hFF10, 16'hA547, 1'b1);
        standby(1'b0);
        rd(16'hFF10, 8'h1F);
        standby(1'b1);
        rd(16'hFF10, 8'h18);
        $display("Test standby done");
        wr(16'hFF1E, 16'h5A40, 1'b1);
        rd(16'hFF1F, 8'h7F);
        wr(16'hFF10, 16'hA560, 1'b1);
        wr(16'hFF10, 16'h5AFE, 1'b1);
        wait_sig(1, 1'b1, 100, 1'b0);
        wait_sig(1, 1'b0, 600, 1'b0);
        @(posedge clk);
        #1;
        chk("chip reset length", 32'd518, chip_len);
        chk("reset pin length", 32'd132, reset_out_pin_len);
        chk("irq in watchdog", 32'h0, {31'h0, irq_in_rst});
        rd(16'hFF1F, 8'hFF);
        rd(16'hFF10, 8'h18);
        wr(16'hFF1E, 16'hA500, 1'b1);
        rd(16'hFF1F, 8'h7F);
        $display("Test watchdog done");
        report_and_stop();
    end
endmodule
